// ---- common/cfra_pkg.sv ----
/*
 * Shared constants and carriers for the card file record addressing unit.
 * Assumes one card clock and that all users import the whole package.
 */
package cfra_pkg;

   // ************************************************************
   // Widths and limits.
   // ************************************************************
   localparam int           REC_W       = 8;
   localparam int           ADDR_W      = 16;
   localparam int           TAG_W       = 16;
   localparam int           TAG_DEPTH   = 8;
   localparam logic [7:0]   MAX_RECS    = 8'hFE;
   localparam logic [7:0]   MAX_CYC_LEN = 8'hFE;
   localparam logic [7:0]   PTR_UNSET   = 8'h00;
   localparam logic [7:0]   FIRST_REC   = 8'h01;
   localparam logic [15:0]  FIRST_BYTE  = 16'h0000;

   // ************************************************************
   // Encodings.
   // ************************************************************
   typedef enum logic [1:0] {
      CFRA_TRANSP, CFRA_LINEAR, CFRA_CYCLIC, CFRA_TLV
   } cfra_ftype_t;

   typedef enum logic [1:0] {
      CFRA_ABS, CFRA_NEXT, CFRA_PREV, CFRA_CUR
   } cfra_mode_t;

   typedef enum logic [2:0] {
      CFRA_READ, CFRA_UPDATE, CFRA_SEARCH, CFRA_TAG_ADD, CFRA_TAG_DEL
   } cfra_op_t;

   // ************************************************************
   // Carriers.
   // ************************************************************
   typedef struct packed {
      cfra_ftype_t         ftype;
      logic [REC_W-1:0]    rec_len;
      logic [REC_W-1:0]    rec_cnt;
      logic [ADDR_W-1:0]   size;
   } cfra_sel_t;

   typedef struct packed {
      logic [REC_W-1:0]    rec_len;
      logic [ADDR_W-1:0]   total_len;
   } cfra_info_t;

   typedef struct packed {
      cfra_op_t            op;
      cfra_mode_t          mode;
      logic [REC_W-1:0]    rec_num;
      logic [ADDR_W-1:0]   offset;
      logic [ADDR_W-1:0]   count;
      logic [TAG_W-1:0]    tag;
   } cfra_req_t;

   typedef struct packed {
      logic                err;
      logic [REC_W-1:0]    rec_num;
      logic [ADDR_W-1:0]   addr;
      logic [ADDR_W-1:0]   len;
   } cfra_ans_t;

endpackage : cfra_pkg

// ---- design/cfra_tag_table.sv ----
/*
 * Tag table of the currently selected tag-length-value file.
 * Assumes the caller never adds a tag that is already present.
 */
`timescale 1ns/1ps
module cfra_tag_table
   import cfra_pkg::*;
#(
   parameter int DEPTH = TAG_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clear,
   input  wire logic [TAG_W-1:0] look_tag,
   output logic                  hit,
   output logic                  full,
   input  wire logic             wr_add,
   input  wire logic             wr_del
);

   // ************************************************************
   // Storage and lookup.
   // ************************************************************
   logic [TAG_W-1:0] tags [DEPTH];
   logic [DEPTH-1:0] used;
   logic [DEPTH-1:0] match;
   logic [DEPTH-1:0] free_one;

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         match[i] = used[i] && (tags[i] == look_tag);
      end
   end

   // Lowest free slot only, so one add never fills two slots.
   assign free_one = ~used & (used + 1'b1);
   assign hit      = |match;
   assign full     = &used;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         used <= '0;
      end else if (clear) begin
         used <= '0;
      end else if (wr_add) begin
         used <= used | free_one;
      end else if (wr_del) begin
         used <= used & ~match;
      end
   end

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (wr_add && free_one[i]) begin
            tags[i] <= look_tag;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   tag_unique_add_a:
   assert property (wr_add && !clear |-> !hit ##1 hit)
      else $error("Tag added twice or not stored.");

endmodule : cfra_tag_table

// ---- design/cfra_addr_unit.sv ----
/*
 * Record pointer and address unit for transparent, linear, cyclic and
 * tag-length-value stored files.
 * Assumes a command processor that selects a file, issues requests,
 * compares search patterns against storage, and commits or aborts.
 */
`timescale 1ns/1ps

// How it works
// - Transparent files use byte offset plus count, first byte at zero.
// - Linear record numbering starts at record 1, all records equal length.
// - Selection reports record length and length times record count.
// - Any linear record is reachable directly by its number.
// - Unset pointer: next gives first record, previous gives last.
// - Set pointer in linear file: current, next unless last, prev unless 1.
// - Search walks records and takes the first pattern match.
// - An aborted operation leaves the pointer where it was.
// - Linear files hold at most 254 records of at most 255 bytes.
// - Cyclic files hold at most 254 records of at most 254 bytes.
// - Cyclic next from last record wraps to record 1.
// - Cyclic previous from record 1 wraps to last record.
// - Cyclic record 1 is newest data, record n the oldest.
// - Cyclic store overwrites the oldest record.
// - Cyclic updates accept only previous mode.
// - Cyclic reads accept next, previous, current and record number.
// - A tag occurs at most once in a tag-length-value file.
module cfra_addr_unit
   import cfra_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              sel_valid,
   input  wire cfra_sel_t         sel,
   output logic                   sel_err,
   output cfra_info_t             info,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire cfra_req_t         req,
   output logic                   ans_valid,
   output cfra_ans_t              ans,
   input  wire logic              done_ok,
   input  wire logic              done_abort,
   output logic                   scan_valid,
   output logic [ADDR_W-1:0]      scan_addr,
   input  wire logic              scan_match,
   output logic [REC_W-1:0]       rec_ptr
);

   // ************************************************************
   // Helpers.
   // ************************************************************
   function automatic logic [REC_W-1:0] cfra_phys(
      input logic             cyc,
      input logic [REC_W-1:0] head,
      input logic [REC_W-1:0] k,
      input logic [REC_W-1:0] n
   );
      logic [REC_W:0] s;
      s = {1'b0, head} + {1'b0, k} - {1'b0, FIRST_REC};
      if (!cyc) begin
         s = {1'b0, k} - {1'b0, FIRST_REC};
      end else if (s >= {1'b0, n}) begin
         s = s - {1'b0, n};
      end
      return s[REC_W-1:0];
   endfunction : cfra_phys

   function automatic logic [ADDR_W-1:0] cfra_base(
      input logic [REC_W-1:0] idx,
      input logic [REC_W-1:0] len
   );
      return {8'h00, idx} * {8'h00, len};
   endfunction : cfra_base

   typedef enum logic [1:0] {CFRA_IDLE, CFRA_SCAN, CFRA_PEND} cfra_state_t;

   // ************************************************************
   // State.
   // ************************************************************
   cfra_state_t         state;
   cfra_state_t         next_state;
   cfra_sel_t           file;
   logic [REC_W-1:0]    ptr;
   logic [REC_W-1:0]    head;
   logic [REC_W-1:0]    scan_idx;
   logic [REC_W-1:0]    pend_ptr;
   logic [REC_W-1:0]    pend_head;
   logic                pend_add;
   logic                pend_del;
   logic [TAG_W-1:0]    pend_tag;
   logic [REC_W-1:0]    tgt;
   logic                tgt_err;
   logic                next_err;
   logic                tag_hit;
   logic                tag_full;

   wire take     = req_valid && req_ready;
   wire is_cyc   = file.ftype == CFRA_CYCLIC;
   wire is_rec   = is_cyc || file.ftype == CFRA_LINEAR;
   wire rd_wr    = req.op == CFRA_READ || req.op == CFRA_UPDATE;
   wire cyc_upd  = is_cyc && req.op == CFRA_UPDATE;
   wire commit   = state == CFRA_PEND && done_ok && !done_abort;
   wire at_last  = ptr == file.rec_cnt;
   wire scan_end = scan_idx == file.rec_cnt;
   wire [ADDR_W:0] tr_end = {1'b0, req.offset} + {1'b0, req.count};
   wire sel_cyc  = sel.ftype == CFRA_CYCLIC;
   wire sel_rec  = sel_cyc || sel.ftype == CFRA_LINEAR;
   // Record length is eight bits wide, so 255 bytes is the hard ceiling.
   wire sel_bad  = sel_rec && (sel.rec_cnt == PTR_UNSET
                   || sel.rec_cnt > MAX_RECS
                   || sel.rec_len == PTR_UNSET
                   || (sel_cyc && sel.rec_len > MAX_CYC_LEN));
   wire [REC_W-1:0] tgt_phys = cfra_phys(is_cyc, head, tgt, file.rec_cnt);
   wire [REC_W-1:0] nxt_scan = scan_idx + FIRST_REC;
   wire [TAG_W-1:0] look_tag = state == CFRA_PEND ? pend_tag : req.tag;

   assign req_ready  = state == CFRA_IDLE && !sel_valid;
   assign scan_valid = state == CFRA_SCAN;
   assign rec_ptr    = ptr;

   // ************************************************************
   // Target record for pointer-based and numbered access.
   // ************************************************************
   always_comb begin
      tgt     = ptr;
      tgt_err = 1'b0;
      case (req.mode)
         CFRA_ABS: begin
            tgt     = req.rec_num;
            tgt_err = req.rec_num == PTR_UNSET
                      || req.rec_num > file.rec_cnt;
         end
         CFRA_NEXT: begin
            if (ptr == PTR_UNSET) begin
               tgt = FIRST_REC;
            end else if (at_last) begin
               tgt     = FIRST_REC;
               tgt_err = !is_cyc;
            end else begin
               tgt = ptr + FIRST_REC;
            end
         end
         CFRA_PREV: begin
            if (ptr == PTR_UNSET) begin
               tgt = file.rec_cnt;
            end else if (ptr == FIRST_REC) begin
               tgt     = file.rec_cnt;
               tgt_err = !is_cyc;
            end else begin
               tgt = ptr - FIRST_REC;
            end
         end
         CFRA_CUR: begin
            tgt_err = ptr == PTR_UNSET;
         end
         default: begin
            tgt_err = 1'b1;
         end
      endcase
      // A cyclic store always lands on the oldest slot.
      if (cyc_upd) begin
         tgt     = file.rec_cnt;
         tgt_err = req.mode != CFRA_PREV;
      end
   end

   always_comb begin
      case (file.ftype)
         CFRA_TRANSP: next_err = !rd_wr || tr_end > {1'b0, file.size};
         CFRA_TLV: begin
            if (req.op == CFRA_TAG_ADD) begin
               next_err = tag_hit || tag_full;
            end else begin
               next_err = req.op == CFRA_SEARCH || !tag_hit;
            end
         end
         default: begin
            // Reads take all four modes in both record kinds.
            next_err = req.op != CFRA_SEARCH
                       && (!rd_wr || tgt_err);
         end
      endcase
      next_err = next_err || sel_err;
   end

   // ************************************************************
   // Sequencer.
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         CFRA_IDLE: begin
            if (take && !next_err) begin
               next_state = (is_rec && req.op == CFRA_SEARCH)
                            ? CFRA_SCAN : CFRA_PEND;
            end
         end
         CFRA_SCAN: begin
            if (scan_match) begin
               next_state = CFRA_PEND;
            end else if (scan_end) begin
               next_state = CFRA_IDLE;
            end
         end
         CFRA_PEND: begin
            if (done_ok || done_abort) begin
               next_state = CFRA_IDLE;
            end
         end
         default: next_state = CFRA_IDLE;
      endcase
      if (sel_valid) begin
         next_state = CFRA_IDLE;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= CFRA_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // File selection and pointer.
   // ************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         file    <= '0;
         sel_err <= 1'b0;
         info    <= '0;
         ptr     <= PTR_UNSET;
         head    <= PTR_UNSET;
      end else if (sel_valid) begin
         file           <= sel;
         sel_err        <= sel_bad;
         info.rec_len   <= sel.rec_len;
         info.total_len <= cfra_base(sel.rec_cnt, sel.rec_len);
         ptr            <= PTR_UNSET;
         head           <= PTR_UNSET;
      end else if (commit) begin
         // Abort takes no branch here, so the pointer stays put.
         ptr  <= pend_ptr;
         head <= pend_head;
      end
   end

   // ************************************************************
   // Answer, pending commit data and search walk.
   // ************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ans_valid <= 1'b0;
         ans       <= '0;
         pend_ptr  <= PTR_UNSET;
         pend_head <= PTR_UNSET;
         pend_add  <= 1'b0;
         pend_del  <= 1'b0;
         pend_tag  <= '0;
         scan_idx  <= FIRST_REC;
         scan_addr <= FIRST_BYTE;
      end else begin
         ans_valid <= 1'b0;
         if (take && !(is_rec && req.op == CFRA_SEARCH && !next_err)) begin
            ans_valid   <= 1'b1;
            ans.err     <= next_err;
            ans.rec_num <= is_rec ? tgt : PTR_UNSET;
            ans.addr    <= is_rec ? cfra_base(tgt_phys, file.rec_len)
                         : (file.ftype == CFRA_TRANSP ? req.offset
                            : FIRST_BYTE);
            ans.len     <= is_rec ? {8'h00, file.rec_len}
                         : (file.ftype == CFRA_TRANSP ? req.count
                            : FIRST_BYTE);
            pend_ptr    <= (!is_rec || req.mode == CFRA_ABS) ? ptr : tgt;
            pend_head   <= cyc_upd ? tgt_phys : head;
            pend_add    <= file.ftype == CFRA_TLV && req.op == CFRA_TAG_ADD;
            pend_del    <= file.ftype == CFRA_TLV && req.op == CFRA_TAG_DEL;
            pend_tag    <= req.tag;
            if (cyc_upd) begin
               pend_ptr <= FIRST_REC;
            end
         end else if (take) begin
            scan_idx  <= FIRST_REC;
            scan_addr <= cfra_base(cfra_phys(is_cyc, head, FIRST_REC,
                                   file.rec_cnt), file.rec_len);
            pend_head <= head;
            pend_add  <= 1'b0;
            pend_del  <= 1'b0;
         end else if (state == CFRA_SCAN) begin
            if (scan_match || scan_end) begin
               ans_valid   <= 1'b1;
               ans.err     <= !scan_match;
               ans.rec_num <= scan_idx;
               ans.addr    <= scan_addr;
               ans.len     <= {8'h00, file.rec_len};
               pend_ptr    <= scan_idx;
            end else begin
               scan_idx  <= nxt_scan;
               scan_addr <= cfra_base(cfra_phys(is_cyc, head, nxt_scan,
                                      file.rec_cnt), file.rec_len);
            end
         end
      end
   end

   cfra_tag_table #(
      .DEPTH    (TAG_DEPTH)
   ) u_tags (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (sel_valid),
      .look_tag (look_tag),
      .hit      (tag_hit),
      .full     (tag_full),
      .wr_add   (commit && pend_add),
      .wr_del   (commit && pend_del)
   );

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   ptr_clear_sel_a:
   assert property (sel_valid |=> ptr == PTR_UNSET)
      else $error("Pointer not cleared on select.");

   abort_keeps_ptr_a:
   assert property (state == CFRA_PEND && done_abort && !sel_valid
                    |=> ptr == $past(ptr))
      else $error("Abort moved the pointer.");

   cyc_update_mode_a:
   assert property (take && cyc_upd && req.mode != CFRA_PREV
                    |=> ans_valid && ans.err)
      else $error("Cyclic update in wrong mode accepted.");

   abs_range_err_a:
   assert property (take && is_rec && rd_wr && req.mode == CFRA_ABS
                    && (req.rec_num == PTR_UNSET
                        || req.rec_num > file.rec_cnt)
                    |=> ans_valid && ans.err ##1 ptr == $past(ptr, 2))
      else $error("Bad record number accepted.");

   total_len_rep_a:
   assert property (sel_valid |=> info.total_len
                    == ADDR_W'({8'h00, $past(sel.rec_len)}
                               * {8'h00, $past(sel.rec_cnt)}))
      else $error("Reported file length is wrong.");

   rec_count_lim_a:
   assert property (sel_valid && sel_rec && sel.rec_cnt > MAX_RECS
                    |=> sel_err)
      else $error("Too many records accepted.");

   cyc_len_lim_a:
   assert property (sel_valid && sel_cyc && sel.rec_len > MAX_CYC_LEN
                    |=> sel_err)
      else $error("Cyclic record too long accepted.");

   next_wrap_a:
   assert property (take && is_cyc && req.op == CFRA_READ && !sel_err
                    && req.mode == CFRA_NEXT && at_last
                    ##1 (done_ok && !done_abort && !sel_valid)
                    |=> ptr == FIRST_REC)
      else $error("Cyclic next did not wrap.");

   prev_wrap_a:
   assert property (take && is_cyc && req.op == CFRA_READ && !sel_err
                    && req.mode == CFRA_PREV && ptr == FIRST_REC
                    ##1 (done_ok && !done_abort && !sel_valid)
                    |=> ptr == file.rec_cnt)
      else $error("Cyclic previous did not wrap.");

   unset_next_a:
   assert property (take && is_rec && req.op == CFRA_READ && !sel_err
                    && req.mode == CFRA_NEXT && ptr == PTR_UNSET
                    |=> ans_valid && !ans.err && ans.rec_num == FIRST_REC)
      else $error("Unset next did not give record 1.");

   lin_last_next_a:
   assert property (take && file.ftype == CFRA_LINEAR && rd_wr
                    && req.mode == CFRA_NEXT && at_last
                    && ptr != PTR_UNSET |=> ans_valid && ans.err)
      else $error("Linear next past last accepted.");

   trans_offset_a:
   assert property (take && file.ftype == CFRA_TRANSP && !next_err
                    |=> ans_valid && ans.addr == $past(req.offset))
      else $error("Transparent address wrong.");

   search_hit_a:
   assert property (state == CFRA_SCAN && scan_match && !sel_valid
                    |=> ans_valid && !ans.err
                    && ans.rec_num == $past(scan_idx))
      else $error("Search match not reported.");

endmodule : cfra_addr_unit

// ---- bench/cfra_proc_model.sv ----
/*
 * Pattern compare of the command processor beside the addressing unit.
 * Assumes the bench names the byte address of the record that matches.
 */
`timescale 1ns/1ps
module cfra_proc_model
   import cfra_pkg::*;
(
   input  wire logic              scan_valid,
   input  wire logic [ADDR_W-1:0] scan_addr,
   input  wire logic              match_en,
   input  wire logic [ADDR_W-1:0] match_addr,
   output logic                   scan_match
);
   // Answers in the compare cycle itself, so no pattern is buffered.
   assign scan_match = scan_valid & match_en
                       & (scan_addr == match_addr);
endmodule : cfra_proc_model

// ---- bench/tb_cfra_addr_unit.sv ----
/*
 * Self-checking bench of the card file record addressing unit.
 * Assumes a 10 MHz core clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ps
module tb_cfra_addr_unit
   import cfra_pkg::*;
;
   // ************************************************************
   // Signals and reference model state.
   // ************************************************************
   logic              core_clk, rst, sel_valid, req_valid, done_ok;
   logic              done_abort, sel_err, req_ready, ans_valid;
   logic              scan_valid, scan_match, match_en;
   cfra_sel_t         sel;
   cfra_info_t        info;
   cfra_req_t         req;
   cfra_ans_t         ans;
   logic [ADDR_W-1:0] scan_addr, match_addr;
   logic [REC_W-1:0]  rec_ptr;
   logic [31:0]       seed;
   int                n_mismatch, cmp_count, ft, n, rl, sz, ptr, head, bad;
   bit                tags[int];

   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end

   cfra_addr_unit dut (.core_clk(core_clk), .rst(rst),
      .sel_valid(sel_valid), .sel(sel), .sel_err(sel_err), .info(info),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .ans_valid(ans_valid), .ans(ans), .done_ok(done_ok),
      .done_abort(done_abort), .scan_valid(scan_valid),
      .scan_addr(scan_addr), .scan_match(scan_match), .rec_ptr(rec_ptr));

   cfra_proc_model proc (.scan_valid(scan_valid), .scan_addr(scan_addr),
      .match_en(match_en), .match_addr(match_addr),
      .scan_match(scan_match));

   // ************************************************************
   // Helpers.
   // ************************************************************
   function automatic int rnd(input int m);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed % m);
   endfunction : rnd

   function automatic int slot(input int t);
      return ft == 2 ? (head + t - 1) % n : t - 1;
   endfunction : slot

   task automatic test_done();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_sig(input int which);
      int i;
      for (i = 0; i < 60; i++) begin
         if ((which ? ans_valid : req_ready) === 1'b1)
            break;
         @(negedge core_clk);
      end
      if (i == 60) begin
         chk(0, 1);
         test_done();
      end
   endtask : wait_sig

   task automatic do_sel(input int t, input int l, input int c,
                         input int s);
      sel = '{cfra_ftype_t'(t), l[7:0], c[7:0], s[15:0]};
      sel_valid = 1;
      @(negedge core_clk);
      sel_valid = 0;
      @(negedge core_clk);
      {ft, n, rl, sz} = {t, c, l, s};
      ptr = 0;
      head = 0;
      tags.delete();
      bad = (t == 1 || t == 2) && (c == 0 || c > 254 || l == 0
            || (t == 2 && l > 254));
      chk(sel_err, bad);
      chk(info, {l[7:0], 16'(l * c)});
      chk(rec_ptr, 0);
   endtask : do_sel

   task automatic do_req(input int o, input int m, input int k,
                         input int off, input int cnt, input int fin);
      int t, e, a, ln, cu;
      e = 0;
      t = k;
      a = 0;
      ln = rl;
      cu = (ft == 2 && o == 1);
      if (ft == 0) begin
         e = (o > 1) || (off + cnt > sz);
         {a, ln} = {off, cnt};
      end else if (ft == 3)
         e = o == 3 ? tags.exists(k) || tags.num() >= TAG_DEPTH
                    : !tags.exists(k);
      else begin
         if (o == 2) begin
            t = k;
            e = (k == 0 || k > n);
         end else if (m == 0)
            e = (k == 0 || k > n);
         else if (m == 1)
            t = ptr == 0 ? 1 : ptr == n ? (ft == 2 ? 1 : 0) : ptr + 1;
         else if (m == 2)
            t = ptr == 0 ? n : ptr == 1 ? (ft == 2 ? n : 0) : ptr - 1;
         else
            t = ptr;
         if (m != 0 && o != 2)
            e = (t == 0);
         if (o > 2)
            e = 1;
         if (cu) begin
            e = (m != 2);
            t = n;
         end
         a = slot(t) * rl;
      end
      e = e | bad;
      wait_sig(0);
      req = '{cfra_op_t'(o), cfra_mode_t'(m), k[7:0], off[15:0],
              cnt[15:0], k[15:0]};
      match_en = (o == 2);
      match_addr = a[15:0];
      req_valid = 1;
      @(negedge core_clk);
      req_valid = 0;
      wait_sig(1);
      chk(ans.err, e);
      if (!e && ft != 3) begin
         chk(ans.addr, a);
         chk(ans.len, ln);
         if (ft != 0 && !cu)
            chk(ans.rec_num, t);
      end
      if (!e) begin
         done_ok = fin[0];
         done_abort = !fin[0];
         @(negedge core_clk);
         {done_ok, done_abort} = 2'b00;
         @(negedge core_clk);
         if (fin && ft == 3 && o == 3)
            tags[k] = 1;
         if (fin && ft == 3 && o == 4)
            tags.delete(k);
         if (fin && cu)
            {head, ptr} = {slot(n), 32'd1};
         else if (fin && ft != 3 && ft != 0 && (m != 0 || o == 2))
            ptr = t;
      end else begin
         // Let an edge pass so the next request is not raised at once.
         @(negedge core_clk);
      end
      chk(rec_ptr, ptr);
   endtask : do_req

   // ************************************************************
   // Scenarios.
   // ************************************************************
   initial begin
      {seed, n_mismatch, cmp_count} = {32'h0000_0009, 32'd0, 32'd0};
      rst = 1;
      {sel_valid, req_valid, done_ok, done_abort, match_en} = '0;
      {sel, req, match_addr} = '0;
      repeat (3) @(negedge core_clk);
      rst = 0;
      do_sel(0, 0, 0, 100);
      do_req(0, 0, 0, 0, 100, 1);
      do_req(1, 0, 0, 1, 100, 1);
      for (int i = 0; i < 6; i++)
         do_req(rnd(3), 0, 0, rnd(80), rnd(40), 1);
      do_sel(1, 8, 255, 0);
      do_req(0, 1, 0, 0, 0, 1);
      do_sel(2, 255, 4, 0);
      do_sel(1, 0, 3, 0);
      do_sel(1, 10, 4, 0);
      do_req(0, 1, 0, 0, 0, 0);
      do_req(0, 2, 0, 0, 0, 1);
      do_req(0, 1, 0, 0, 0, 1);
      for (int k = 0; k < 6; k++)
         do_req(0, 0, k, 0, 0, 1);
      for (int i = 0; i < 5; i++)
         do_req(1, i == 0 ? 3 : 2, 0, 0, 0, 1);
      do_req(2, 0, 3, 0, 0, 1);
      do_req(2, 0, 5, 0, 0, 1);
      do_req(0, 3, 0, 0, 0, 1);
      do_sel(1, 10, 4, 0);
      do_req(0, 3, 0, 0, 0, 1);
      do_sel(2, 254, 3, 0);
      do_req(1, 1, 0, 0, 0, 1);
      // Updates are mostly previous mode, as a real requester sends.
      for (int i = 0; i < 40; i++)
         do_req(rnd(2), rnd(4) == 0 ? rnd(4) : 2, rnd(5), 0, 0,
                rnd(4) != 0);
      do_req(2, 0, 2, 0, 0, 1);
      // A card reset in mid-run must drop the pointer and the selection.
      rst = 1;
      @(negedge core_clk);
      chk(rec_ptr, 0);
      rst = 0;
      chk(info, 0);
      do_sel(3, 0, 0, 0);
      do_req(3, 0, 5, 0, 0, 1);
      do_req(3, 0, 5, 0, 0, 1);
      do_req(0, 0, 5, 0, 0, 1);
      do_req(4, 0, 5, 0, 0, 1);
      do_req(0, 0, 5, 0, 0, 1);
      for (int k = 1; k < 11; k++)
         do_req(3, 0, k, 0, 0, 1);
      test_done();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      chk(0, 1);
      test_done();
   end
endmodule : tb_cfra_addr_unit
